// file: inc/modem_pin_pkg.sv
// Package of register map, field positions and timing constants for the modem pin block
package modem_pin_pkg;

  // ==========================================================================
  // Register byte offsets on APB
  localparam logic [7:0] OFF_PIN_MODE  = 8'h00;
  localparam logic [7:0] OFF_GPIO_DIR  = 8'h04;
  localparam logic [7:0] OFF_GPIO_DOUT = 8'h08;
  localparam logic [7:0] OFF_GPIO_DIN  = 8'h0C;
  localparam logic [7:0] OFF_INT_CTRL  = 8'h10;
  localparam logic [7:0] OFF_CTRL      = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h1C;
  localparam logic [7:0] OFF_STATUS    = 8'h20;

  // ==========================================================================
  // Pin map: bit k serves general_io_(k+1)
  localparam int          NUM_PINS      = 5;
  localparam int          PIN_FRAME_END = 0;
  localparam int          PIN_CARRIER   = 1;
  localparam int          PIN_ESCAPE    = 2;
  localparam int          PIN_INTR      = 3;
  localparam int          PIN_RING      = 4;
  // Alternate functions that drive their pin; escape is an input
  localparam logic [4:0]  ALT_DRIVES    = 5'h1B;

  // ==========================================================================
  // Field positions and reset values
  localparam int          INT_CLR_LSB   = 6;
  localparam int          INT_PEND_BIT  = 7;
  localparam int          CTRL_POLICY   = 0;
  localparam int          CTRL_CLK_LSB  = 1;
  localparam int          CTRL_SLEEP    = 3;
  localparam int          IRQ_ESCAPE    = 0;
  localparam int          IRQ_FRAME_END = 1;
  localparam int          IRQ_RING      = 2;
  localparam int          IRQ_INTR      = 3;
  localparam logic [4:0]  PIN_MODE_RST  = 5'h00;
  localparam logic [4:0]  GPIO_DIR_RST  = 5'h00;
  localparam logic [4:0]  GPIO_DOUT_RST = 5'h00;
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

  // ==========================================================================
  // Reference clock options
  typedef enum logic [1:0] {
    CLK_CRYSTAL  = 2'b00,
    CLK_EXT_LOW  = 2'b01,
    CLK_EXT_HIGH = 2'b10
  } clk_src_t;
  localparam int          CRYSTAL_KHZ   = 4915;
  localparam int          EXT_HIGH_KHZ  = 27000;

  // ==========================================================================
  // Clear-to-send fill thresholds in percent
  localparam int          CTS_OFF_PCT   = 70;
  localparam int          CTS_ON_PCT    = 30;

endpackage

// file: src/modem_pin_cell.sv
// One multiplexed general purpose pin: output mux, enable and input synchroniser
`timescale 1ns/1ps
module modem_pin_cell (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Pad
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_n_out,
  output logic      pad_sync_out,
  // Selection
  input  wire logic alt_en_in,
  input  wire logic alt_drives_in,
  input  wire logic alt_val_in,
  input  wire logic dir_in,
  input  wire logic dout_in
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic out;
    logic oe_n;
  } cell_t;

  cell_t s_q;
  cell_t s_d;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = pad_in;
    s_d.sync2 = s_q.sync1;
    if (alt_en_in) begin
      s_d.out  = alt_drives_in & alt_val_in;
      s_d.oe_n = ~alt_drives_in;
    end else begin
      s_d.out  = dir_in & dout_in;
      s_d.oe_n = ~dir_in;
    end
  end

  // Reset leaves the pad an undriven input
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '{sync1: 1'b0, sync2: 1'b0, out: 1'b0, oe_n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign pad_out      = s_q.out;
  assign pad_oe_n_out = s_q.oe_n;
  assign pad_sync_out = s_q.sync2;

endmodule

// file: src/modem_pin_functions.sv
// Host side pin functions: pin mux, interrupt pin, escape, clear-to-send, APB registers
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module modem_pin_functions #(
  parameter int FIFO_DEPTH = 16,
  parameter int LEVEL_W    = 5
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rstn_in,
  // APB slave
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire logic [7:0]         paddr_in,
  input  wire logic [31:0]        pwdata_in,
  output logic                    pready_out,
  output logic [31:0]             prdata_out,
  output logic                    pslverr_out,
  output logic                    irq_out,
  // Multiplexed pins general_io_1..5 (bit 0 is general_io_1)
  input  wire logic [4:0]         general_io_in,
  output logic [4:0]              general_io_out,
  output logic [4:0]              general_io_oe_n_out,
  // Serial flow control
  output logic                    cts_n_out,
  // Modem core status
  input  wire logic               connected_in,
  input  wire logic               carrier_present_in,
  input  wire logic               ring_on_in,
  input  wire logic               frame_end_in,
  input  wire logic               carrier_lost_in,
  input  wire logic               wake_ring_in,
  input  wire logic               loop_loss_in,
  input  wire logic               v23_reversal_in,
  input  wire logic               intrusion_in,
  input  wire logic               start_bit_in,
  input  wire logic               tx_fifo_empty_in,
  input  wire logic [LEVEL_W-1:0] tx_fifo_level_in,
  // Modem core control
  output logic                    escape_cmd_out,
  output logic                    command_mode_out,
  output logic [1:0]              clk_sel_out,
  output logic                    osc_amp_en_out,
  output logic                    sleep_out
);

  // ==========================================================================
  // Thresholds, compared as level*100 against depth*percent
  localparam logic [15:0] OFF_MARK = 16'(FIFO_DEPTH * modem_pin_pkg::CTS_OFF_PCT);
  localparam logic [15:0] ON_MARK  = 16'(FIFO_DEPTH * modem_pin_pkg::CTS_ON_PCT);

  typedef struct packed {
    logic [4:0]  pin_alt;
    logic [4:0]  gpio_dir;
    logic [4:0]  gpio_dout;
    logic        policy;
    logic [1:0]  clk_src;
    logic        osc_en;
    logic        sleep;
    logic [4:0]  int_src;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic        irq;
    logic        cts_n;
    logic        esc_prev;
    logic        cmd_mode;
    logic        esc_cmd;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [4:0]  pad_sync;
  logic [4:0]  alt_val;
  logic [15:0] level_pct;
  logic        esc_rise;
  logic        wr_en;
  logic        setup;
  logic        mapped;

  // ==========================================================================
  // Pin cells
  assign alt_val[modem_pin_pkg::PIN_FRAME_END] = frame_end_in;
  assign alt_val[modem_pin_pkg::PIN_CARRIER]   = ~carrier_present_in;
  assign alt_val[modem_pin_pkg::PIN_ESCAPE]    = 1'b0;
  assign alt_val[modem_pin_pkg::PIN_INTR]      = |s_d.int_src;
  assign alt_val[modem_pin_pkg::PIN_RING]      = ring_on_in;

  for (genvar k = 0; k < modem_pin_pkg::NUM_PINS; k++) begin : g_pin
    // Function select per pin
    modem_pin_cell u_cell (
      .clk_in        (clk_in),
      .rstn_in       (rstn_in),
      .pad_in        (general_io_in[k]),
      .pad_out       (general_io_out[k]),
      .pad_oe_n_out  (general_io_oe_n_out[k]),
      .pad_sync_out  (pad_sync[k]),
      .alt_en_in     (s_q.pin_alt[k]),
      .alt_drives_in (modem_pin_pkg::ALT_DRIVES[k]),
      .alt_val_in    (alt_val[k]),
      .dir_in        (s_q.gpio_dir[k]),
      .dout_in       (s_q.gpio_dout[k])
    );
  end

  // ==========================================================================
  // Bus decode
  assign setup     = psel_in & ~penable_in;
  assign wr_en     = psel_in & penable_in & s_q.pready & pwrite_in & ~s_q.pslverr;
  assign esc_rise  = s_q.pin_alt[modem_pin_pkg::PIN_ESCAPE] &
                     pad_sync[modem_pin_pkg::PIN_ESCAPE] & ~s_q.esc_prev;
  assign level_pct = 16'(tx_fifo_level_in) * 16'd100;

  always_comb begin
    case (paddr_in)
      modem_pin_pkg::OFF_PIN_MODE,
      modem_pin_pkg::OFF_GPIO_DIR,
      modem_pin_pkg::OFF_GPIO_DOUT,
      modem_pin_pkg::OFF_GPIO_DIN,
      modem_pin_pkg::OFF_INT_CTRL,
      modem_pin_pkg::OFF_CTRL,
      modem_pin_pkg::OFF_IRQ_STAT,
      modem_pin_pkg::OFF_IRQ_MASK,
      modem_pin_pkg::OFF_STATUS: mapped = 1'b1;
      default:                   mapped = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // One wait-free access cycle after each setup
    s_d.pready  = setup;
    s_d.pslverr = setup & ~mapped;
    s_d.prdata  = 32'h0000_0000;
    if (setup && !pwrite_in) begin
      case (paddr_in)
        modem_pin_pkg::OFF_PIN_MODE:  s_d.prdata[4:0] = s_q.pin_alt;
        modem_pin_pkg::OFF_GPIO_DIR:  s_d.prdata[4:0] = s_q.gpio_dir;
        modem_pin_pkg::OFF_GPIO_DOUT: s_d.prdata[4:0] = s_q.gpio_dout;
        modem_pin_pkg::OFF_GPIO_DIN:  s_d.prdata[4:0] = pad_sync;
        modem_pin_pkg::OFF_INT_CTRL: begin
          s_d.prdata[4:0]                         = s_q.int_src;
          s_d.prdata[modem_pin_pkg::INT_PEND_BIT] = |s_q.int_src;
        end
        modem_pin_pkg::OFF_CTRL: begin
          s_d.prdata[modem_pin_pkg::CTRL_POLICY]                    = s_q.policy;
          s_d.prdata[modem_pin_pkg::CTRL_CLK_LSB +: 2]              = s_q.clk_src;
          s_d.prdata[modem_pin_pkg::CTRL_SLEEP]                     = s_q.sleep;
        end
        modem_pin_pkg::OFF_IRQ_STAT:  s_d.prdata[3:0] = s_q.irq_stat;
        modem_pin_pkg::OFF_IRQ_MASK:  s_d.prdata[3:0] = s_q.irq_mask;
        modem_pin_pkg::OFF_STATUS:    s_d.prdata[3:0] = {s_q.cts_n, s_q.cmd_mode,
                                                         carrier_present_in, connected_in};
        default:                      s_d.prdata = 32'h0000_0000;
      endcase
    end

    // Register writes take effect at the access edge
    if (wr_en) begin
      case (paddr_in)
        modem_pin_pkg::OFF_PIN_MODE:  s_d.pin_alt   = pwdata_in[4:0];
        modem_pin_pkg::OFF_GPIO_DIR:  s_d.gpio_dir  = pwdata_in[4:0];
        modem_pin_pkg::OFF_GPIO_DOUT: s_d.gpio_dout = pwdata_in[4:0];
        modem_pin_pkg::OFF_INT_CTRL: begin
          if (|pwdata_in[modem_pin_pkg::INT_CLR_LSB +: 2]) begin
            s_d.int_src = 5'h00;
          end
        end
        modem_pin_pkg::OFF_CTRL: begin
          s_d.policy = pwdata_in[modem_pin_pkg::CTRL_POLICY];
          // Only the three documented clock options are accepted
          if (pwdata_in[modem_pin_pkg::CTRL_CLK_LSB +: 2] != 2'b11) begin
            s_d.clk_src = pwdata_in[modem_pin_pkg::CTRL_CLK_LSB +: 2];
          end
          // Sleep is left only through reset
          s_d.sleep = s_q.sleep | pwdata_in[modem_pin_pkg::CTRL_SLEEP];
        end
        modem_pin_pkg::OFF_IRQ_STAT:  s_d.irq_stat = s_q.irq_stat & ~pwdata_in[3:0];
        modem_pin_pkg::OFF_IRQ_MASK:  s_d.irq_mask = pwdata_in[3:0];
        default:                      s_d.irq_mask = s_q.irq_mask;
      endcase
    end

    // Crystal amplifier enable follows the selected clock source
    s_d.osc_en = (s_d.clk_src == modem_pin_pkg::CLK_CRYSTAL);

    // Interrupt pin sources; a set wins over a clear in the same cycle
    if (s_q.pin_alt[modem_pin_pkg::PIN_INTR] && connected_in) begin
      s_d.int_src = s_d.int_src | {intrusion_in, v23_reversal_in, loop_loss_in,
                                   wake_ring_in, carrier_lost_in};
    end

    // Escape edge forces command mode only while connected and not yet in command mode
    s_d.esc_prev = pad_sync[modem_pin_pkg::PIN_ESCAPE];
    s_d.esc_cmd  = esc_rise & connected_in & ~s_q.cmd_mode;
    if (s_d.esc_cmd) begin
      s_d.cmd_mode = 1'b1;
    end else if (!connected_in) begin
      s_d.cmd_mode = 1'b0;
    end

    // Clear-to-send flow control
    if (!s_q.policy) begin
      if (start_bit_in) begin
        s_d.cts_n = 1'b1;
      end else if (tx_fifo_empty_in) begin
        s_d.cts_n = 1'b0;
      end
    end else begin
      if (level_pct >= OFF_MARK) begin
        s_d.cts_n = 1'b1;
      end else if (level_pct <= ON_MARK) begin
        s_d.cts_n = 1'b0;
      end
    end

    // Sticky event status and masked interrupt
    s_d.irq_stat[modem_pin_pkg::IRQ_ESCAPE]    = s_d.irq_stat[modem_pin_pkg::IRQ_ESCAPE] |
                                                 s_d.esc_cmd;
    s_d.irq_stat[modem_pin_pkg::IRQ_FRAME_END] = s_d.irq_stat[modem_pin_pkg::IRQ_FRAME_END] |
                                                 frame_end_in;
    s_d.irq_stat[modem_pin_pkg::IRQ_RING]      = s_d.irq_stat[modem_pin_pkg::IRQ_RING] |
                                                 ring_on_in;
    s_d.irq_stat[modem_pin_pkg::IRQ_INTR]      = s_d.irq_stat[modem_pin_pkg::IRQ_INTR] |
                                                 (|s_d.int_src & ~|s_q.int_src);
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  // ==========================================================================
  // State register; reset leaves every pin a digital input
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q          <= '0;
      s_q.pin_alt  <= modem_pin_pkg::PIN_MODE_RST;
      s_q.gpio_dir <= modem_pin_pkg::GPIO_DIR_RST;
      s_q.gpio_dout <= modem_pin_pkg::GPIO_DOUT_RST;
      s_q.irq_mask <= modem_pin_pkg::IRQ_MASK_RST;
      s_q.clk_src  <= modem_pin_pkg::CLK_CRYSTAL;
      s_q.osc_en   <= 1'b1;
      s_q.cts_n    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready_out       = s_q.pready;
  assign prdata_out       = s_q.prdata;
  assign pslverr_out      = s_q.pslverr;
  assign irq_out          = s_q.irq;
  assign cts_n_out        = s_q.cts_n;
  assign escape_cmd_out   = s_q.esc_cmd;
  assign command_mode_out = s_q.cmd_mode;
  assign clk_sel_out      = s_q.clk_src;
  assign osc_amp_en_out   = s_q.osc_en;
  assign sleep_out        = s_q.sleep;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_pin_ring_drive: assert property (
    s_q.pin_alt[modem_pin_pkg::PIN_RING] |=>
      general_io_out[modem_pin_pkg::PIN_RING] == $past(ring_on_in) &&
      !general_io_oe_n_out[modem_pin_pkg::PIN_RING])
    else $error("ring pin does not follow ring state");

  a_carrier_low_active: assert property (
    s_q.pin_alt[modem_pin_pkg::PIN_CARRIER] && carrier_present_in |=>
      !general_io_out[modem_pin_pkg::PIN_CARRIER])
    else $error("carrier detect pin not low while carrier present");

  a_frame_end_pin: assert property (
    s_q.pin_alt[modem_pin_pkg::PIN_FRAME_END] && frame_end_in |=>
      general_io_out[modem_pin_pkg::PIN_FRAME_END])
    else $error("frame end not shown on pin");

  a_gpio_input_idle: assert property (
    !s_q.gpio_dir[0] && !s_q.pin_alt[0] |=> general_io_oe_n_out[0])
    else $error("unconfigured pin drives");

  a_int_sticky_hold: assert property (
    |s_q.int_src && !(wr_en && paddr_in == modem_pin_pkg::OFF_INT_CTRL) |=> |s_q.int_src)
    else $error("interrupt source dropped without clear");

  a_int_event_set: assert property (
    s_q.pin_alt[modem_pin_pkg::PIN_INTR] && connected_in && carrier_lost_in |=>
      s_q.int_src[0] ##1 general_io_out[modem_pin_pkg::PIN_INTR])
    else $error("interrupt event not latched onto pin");

  a_escape_once: assert property (
    s_q.esc_cmd |=> !s_q.esc_cmd [*2])
    else $error("escape pulse repeated");

  a_escape_command: assert property (
    s_q.esc_cmd |-> s_q.cmd_mode && $past(connected_in))
    else $error("escape without switch to command mode");

  a_cts_start_bit: assert property (
    !s_q.policy && start_bit_in |=> cts_n_out)
    else $error("clear to send not negated on start bit");

  a_cts_empty_on: assert property (
    !s_q.policy && !start_bit_in && tx_fifo_empty_in |=> !cts_n_out)
    else $error("clear to send not reasserted on empty fifo");

  a_cts_fill_off: assert property (
    s_q.policy && level_pct >= OFF_MARK |=> cts_n_out)
    else $error("clear to send not negated at high fill");

  a_clk_src_legal: assert property (
    clk_sel_out != 2'b11)
    else $error("illegal reference clock selection");

  a_apb_ready_pulse: assert property (
    setup |=> pready_out ##1 !pready_out)
    else $error("apb ready not a single access cycle");

  c_escape_switch: cover property (s_q.esc_cmd);
  c_int_cleared: cover property (|s_q.int_src ##1 !(|s_q.int_src));
  c_cts_fill_cycle: cover property (s_q.policy && cts_n_out ##[1:50] !cts_n_out);
  c_irq_raised: cover property (irq_out);

endmodule

// file: verif/host_pin_model.sv
// Host processor side of the five multiplexed pins
`timescale 1ns/1ps
module host_pin_model (
  // Host pad values
  input  wire logic [4:0] host_drv_in,
  // Block pad outputs
  input  wire logic [4:0] dev_out_in,
  input  wire logic [4:0] dev_oe_n_in,
  // Resolved pad levels
  output logic      [4:0] pad_out
);
  // ==========================================================================
  // Pad resolution: host keeps off a pad while the block drives it
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pad_out[i] = dev_oe_n_in[i] ? host_drv_in[i] : dev_out_in[i];
    end
  end
endmodule

// file: verif/tb_top.sv
// Self-checking testbench of the modem host pin function block
`timescale 1ns/1ps
module tb_top;
  // ==========================================================================
  // Signals
  localparam int DEPTH = 16;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, irq, cts_n, esc_cmd, cmd_mode, osc_en, sleep;
  logic [4:0]  gio_out, gio_oe_n, pad, host_drv = 5'h00, ev = 5'h00, level = 5'h00;
  logic [1:0]  clk_sel;
  logic        conn = 1'b0, carrier = 1'b0, ring = 1'b0, fend = 1'b0;
  logic        sbit = 1'b0, empty = 1'b1;
  int          num_errors = 0, n_compared = 0, cycles = 0;

  modem_pin_functions #(.FIFO_DEPTH(DEPTH), .LEVEL_W(5)) i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .irq_out(irq), .general_io_in(pad),
    .general_io_out(gio_out), .general_io_oe_n_out(gio_oe_n), .cts_n_out(cts_n),
    .connected_in(conn), .carrier_present_in(carrier), .ring_on_in(ring),
    .frame_end_in(fend), .carrier_lost_in(ev[0]), .wake_ring_in(ev[1]),
    .loop_loss_in(ev[2]), .v23_reversal_in(ev[3]), .intrusion_in(ev[4]),
    .start_bit_in(sbit), .tx_fifo_empty_in(empty), .tx_fifo_level_in(level),
    .escape_cmd_out(esc_cmd), .command_mode_out(cmd_mode), .clk_sel_out(clk_sel),
    .osc_amp_en_out(osc_en), .sleep_out(sleep));

  host_pin_model i_host (.host_drv_in(host_drv), .dev_out_in(gio_out),
    .dev_oe_n_in(gio_oe_n), .pad_out(pad));

  // ==========================================================================
  // Clock, timeout and verdict
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rstn_in <= 1'b0;
    cyc(12);
    chk(gio_oe_n, 5'h1F);
    chk(cts_n, 1'b1);
    chk(sleep, 1'b0);
    rstn_in <= 1'b1;
    rchk(modem_pin_pkg::OFF_PIN_MODE, modem_pin_pkg::PIN_MODE_RST);
    rchk(modem_pin_pkg::OFF_GPIO_DIR, modem_pin_pkg::GPIO_DIR_RST);
    rchk(modem_pin_pkg::OFF_CTRL, 32'h0);
    rchk(modem_pin_pkg::OFF_IRQ_MASK, modem_pin_pkg::IRQ_MASK_RST);
    rchk(8'h24, 32'h0);
    chk(err, 1'b1);
  endtask

  task automatic t_gpio();
    apb(1'b1, modem_pin_pkg::OFF_GPIO_DIR, 32'h1F);
    apb(1'b1, modem_pin_pkg::OFF_GPIO_DOUT, 32'h15);
    cyc(2);
    chk(gio_out, 5'h15);
    chk(gio_oe_n, 5'h00);
    apb(1'b1, modem_pin_pkg::OFF_GPIO_DIR, 32'h00);
    host_drv <= 5'h0A;
    cyc(4);
    chk(gio_oe_n, 5'h1F);
    rchk(modem_pin_pkg::OFF_GPIO_DIN, 32'h0A);
  endtask

  task automatic t_alt();
    apb(1'b1, modem_pin_pkg::OFF_PIN_MODE, 32'h13);
    for (int i = 0; i < 2; i++) begin
      fend <= i[0];
      carrier <= i[0];
      ring <= i[0];
      cyc(3);
      chk(gio_out[0], i[0]);
      chk(gio_out[1], !i[0]);
      chk(gio_out[4], i[0]);
    end
    chk(gio_oe_n, 5'h0C);
  endtask

  task automatic t_intr();
    apb(1'b1, modem_pin_pkg::OFF_PIN_MODE, 32'h08);
    apb(1'b1, modem_pin_pkg::OFF_IRQ_STAT, 32'h0F);
    apb(1'b1, modem_pin_pkg::OFF_IRQ_MASK, 32'h08);
    conn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      ev <= 5'h01 << i;
      cyc(1);
      ev <= 5'h00;
      cyc(6);
      chk(gio_out[3], 1'b1);
      chk(gio_oe_n[3], 1'b0);
      chk(irq, 1'b1);
      rchk(modem_pin_pkg::OFF_INT_CTRL, 32'h80 | (32'h1 << i));
      apb(1'b1, modem_pin_pkg::OFF_INT_CTRL, 32'h3F);
      chk(gio_out[3], 1'b1);
      apb(1'b1, modem_pin_pkg::OFF_IRQ_STAT, 32'h08);
      // Host clears the pin with each nonzero clear code in turn
      apb(1'b1, modem_pin_pkg::OFF_INT_CTRL, (i % 3 + 1) << 6);
      cyc(2);
      chk(gio_out[3], 1'b0);
      chk(irq, 1'b0);
    end
    conn <= 1'b0;
    ev <= 5'h1F;
    cyc(4);
    ev <= 5'h00;
    cyc(3);
    chk(gio_out[3], 1'b0);
  endtask

  task automatic t_escape();
    int cnt;
    apb(1'b1, modem_pin_pkg::OFF_PIN_MODE, 32'h04);
    conn <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      host_drv[2] <= 1'b1;
      cnt = 0;
      repeat (8) begin
        @(posedge clk_in);
        cnt += esc_cmd;
      end
      chk(cnt, k == 0);
      chk(cmd_mode, 1'b1);
      host_drv[2] <= 1'b0;
      cyc(4);
    end
    chk(gio_oe_n[2], 1'b1);
    conn <= 1'b0;
    cyc(3);
    chk(cmd_mode, 1'b0);
  endtask

  task automatic t_cts();
    logic       e;
    logic [4:0] lv [5];
    lv = '{5'd11, 5'd12, 5'd5, 5'd4, 5'd11};
    e = 1'b0;
    empty <= 1'b0;
    sbit <= 1'b1;
    cyc(1);
    sbit <= 1'b0;
    cyc(3);
    chk(cts_n, 1'b1);
    empty <= 1'b1;
    cyc(3);
    chk(cts_n, 1'b0);
    apb(1'b1, modem_pin_pkg::OFF_CTRL, 32'h01);
    for (int i = 0; i < 5; i++) begin
      level <= lv[i];
      cyc(3);
      if (lv[i] * 100 >= DEPTH * modem_pin_pkg::CTS_OFF_PCT) e = 1'b1;
      else if (lv[i] * 100 <= DEPTH * modem_pin_pkg::CTS_ON_PCT) e = 1'b0;
      chk(cts_n, e);
    end
  endtask

  task automatic t_clk_sleep();
    logic [1:0] e2;
    for (int k = 1; k < 5; k++) begin
      apb(1'b1, modem_pin_pkg::OFF_CTRL, (k % 4) << modem_pin_pkg::CTRL_CLK_LSB);
      cyc(2);
      e2 = (k == 3) ? 2'd2 : 2'(k % 4);
      chk(clk_sel, e2);
      chk(osc_en, e2 == 2'd0);
    end
    apb(1'b1, modem_pin_pkg::OFF_PIN_MODE, 32'h1F);
    apb(1'b1, modem_pin_pkg::OFF_CTRL, 32'h1 << modem_pin_pkg::CTRL_SLEEP);
    cyc(2);
    chk(sleep, 1'b1);
    t_reset();
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    t_reset();
    t_gpio();
    t_alt();
    t_intr();
    t_escape();
    t_cts();
    t_clk_sleep();
    report_and_stop();
  end
endmodule
